//--- uirq_pkg.sv
// Package: register map, field positions and types for the UART interrupt and wake block
package uirq_pkg;
  // Register byte offsets
  localparam logic [3:0] UIRQ_OFS_STATUS  = 4'h0;
  localparam logic [3:0] UIRQ_OFS_CTRL1   = 4'h4;
  localparam logic [3:0] UIRQ_OFS_CTRL2   = 4'h8;
  localparam logic [3:0] UIRQ_OFS_SYSCTL  = 4'hC;
  // Control-two field positions
  localparam int UIRQ_C2_TEIE  = 0;
  localparam int UIRQ_C2_TIIE  = 1;
  localparam int UIRQ_C2_RIE   = 2;
  localparam int UIRQ_C2_WAKE  = 3;
  localparam int UIRQ_C2_ADDR_DETECT_ENABLE = 4;
  localparam int UIRQ_C2_RECEIVER_ENABLE  = 5;
  // Control-one field positions
  localparam int UIRQ_C1_UEN   = 0;
  localparam int UIRQ_C1_NINTH = 1;
  localparam int UIRQ_C1_PAR   = 2;
  // System control field positions
  localparam int UIRQ_SC_GIE   = 0;
  localparam int UIRQ_SC_SIE   = 1;
  localparam int UIRQ_SC_PEND  = 2;
  localparam int UIRQ_SC_AWAKE = 3;
  localparam logic [7:0] UIRQ_CTRL_RESET = 8'h00;
  // Post-wake start-up time and its cycle count at 125 MHz
  localparam int UIRQ_CLK_MHZ     = 125;
  localparam int UIRQ_STARTUP_US  = 16;
  localparam int UIRQ_STARTUP_CYC = UIRQ_STARTUP_US * UIRQ_CLK_MHZ;
  localparam logic [7:0] UIRQ_NINTH_MASK = 8'h80;
  // Per-event strobes from the serial core
  typedef struct packed {
    logic txEmpty;
    logic txIdle;
    logic rxLoad;
    logic overrun;
    logic addrDetect;
  } uirq_evt_t;
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } uirq_word_t;
endpackage

//--- uirq_wake.sv
// Rx pin wake detector and post-wake start-up timer
`timescale 1ns/100ps
module uirq_wake
  import uirq_pkg::*;
#(
  parameter int STARTUP_CYC = UIRQ_STARTUP_CYC
)(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Controls
  input  wire logic armed,
  input  wire logic lowPower,
  input  wire logic rxPin,
  // Status
  output logic      wakeReq,
  output logic      startup,
  output logic      wakeDone
);
  logic        rxLast;
  logic [15:0] count;
  wire         fallEdge = rxLast & ~rxPin;
  wire         countEnd = (count == 16'(STARTUP_CYC - 1));

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxLast   <= 1'b1;
      wakeReq  <= 1'b0;
      startup  <= 1'b0;
      count    <= '0;
      wakeDone <= 1'b0;
    end
    else
    begin
      rxLast   <= rxPin;
      wakeDone <= 1'b0;
      if (lowPower && armed && fallEdge && !startup)
      begin
        wakeReq <= 1'b1;
        startup <= 1'b1;
        count   <= '0;
      end
      else if (startup)
      begin
        wakeReq <= 1'b0;
        if (countEnd)
        begin
          startup  <= 1'b0;
          wakeDone <= 1'b1;
        end
        else
          count <= count + 16'h0001;
      end
    end
  end
endmodule

//--- uirq_avalon.sv
// Avalon-MM slave register file for control and status
`timescale 1ns/100ps
module uirq_avalon
  import uirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Avalon-MM
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Register contents
  output logic [7:0]       ctrlOne,
  output logic [7:0]       ctrlTwo,
  output logic [1:0]       sysCtl,
  input  wire logic [7:0]  statusIn,
  input  wire logic [1:0]  sysStat,
  output logic             statusRead
);
  logic done;
  wire  req     = (read | write) & ~done;
  // Writes land on the edge where waitrequest is seen low, as the master expects
  wire  accept  = (read | write) & done;
  wire  hitStat = (address == UIRQ_OFS_STATUS);
  wire  hitC1   = (address == UIRQ_OFS_CTRL1);
  wire  hitC2   = (address == UIRQ_OFS_CTRL2);
  wire  hitSys  = (address == UIRQ_OFS_SYSCTL);
  wire [31:0] next_readdata =
    hitStat ? {24'h000000, statusIn} :
    hitC1   ? {24'h000000, ctrlOne} :
    hitC2   ? {24'h000000, ctrlTwo} :
    hitSys  ? {28'h0000000, sysStat, sysCtl} : 32'h00000000;

  assign waitrequest = (read | write) & ~done;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done       <= 1'b0;
      readdata   <= '0;
      ctrlOne    <= UIRQ_CTRL_RESET;
      ctrlTwo    <= UIRQ_CTRL_RESET;
      sysCtl     <= 2'h0;
      statusRead <= 1'b0;
    end
    else
    begin
      done       <= req;
      statusRead <= req & read & hitStat;
      if (req & read)
        readdata <= next_readdata;
      if (accept & write & hitC1)
        ctrlOne <= writedata[7:0];
      if (accept & write & hitC2)
        ctrlTwo <= writedata[7:0];
      if (accept & write & hitSys)
        sysCtl <= writedata[1:0];
    end
  end
endmodule

//--- uirq_top.sv
// UART interrupt merge, address detect and rx wake-up top
`timescale 1ns/100ps
module uirq_top
  import uirq_pkg::*;
#(
  parameter int STARTUP_CYC = UIRQ_STARTUP_CYC
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Avalon-MM
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Serial core events and state
  input  wire uirq_evt_t   events,
  input  wire uirq_word_t  rxWord,
  input  wire logic        rxBufEmpty,
  input  wire logic        rxBufRead,
  input  wire logic        txEmptyLvl,
  input  wire logic        txIdleLvl,
  input  wire logic        clockStopped,
  input  wire logic        lowPower,
  input  wire logic        stackFull,
  input  wire logic        rxPin,
  // Outputs
  output logic             irq_n,
  output logic             wakeOut,
  output logic             serialRun,
  output logic             rxGate
);
  logic [7:0] ctrlOne;
  logic [7:0] ctrlTwo;
  logic [1:0] sysCtl;
  logic       statusRead;
  logic       wakeReq;
  logic       startup;
  logic       wakeDone;
  logic       wakePend;
  logic       rxAvail;
  logic       overrunFlag;
  logic       armedAtEntry;
  logic       lowPowerLast;
  logic       statusSeen;
  logic       anyReqLast;

  wire uEn    = ctrlOne[UIRQ_C1_UEN];
  wire nineB  = ctrlOne[UIRQ_C1_NINTH];
  wire teie   = ctrlTwo[UIRQ_C2_TEIE];
  wire tiie   = ctrlTwo[UIRQ_C2_TIIE];
  wire receive_irq_enable    = ctrlTwo[UIRQ_C2_RIE];
  wire wakeEn = ctrlTwo[UIRQ_C2_WAKE];
  wire addr_detect_enable  = ctrlTwo[UIRQ_C2_ADDR_DETECT_ENABLE];
  wire receiver_enable   = ctrlTwo[UIRQ_C2_RECEIVER_ENABLE];
  wire gie    = sysCtl[UIRQ_SC_GIE];
  wire sie    = sysCtl[UIRQ_SC_SIE];

  wire topBit = nineB ? rxWord.ninth : |(rxWord.data & UIRQ_NINTH_MASK);
  wire rxLoadOk = events.rxLoad & ~startup & ~clockStopped;
  wire armNow = wakeEn & uEn & receiver_enable & receive_irq_enable;

  wire srcTxE = teie & events.txEmpty;
  wire srcTxI = tiie & events.txIdle;
  wire srcRx  = receive_irq_enable & rxLoadOk & (~addr_detect_enable | topBit);
  wire srcOvr = receive_irq_enable & events.overrun & ~startup;
  wire srcAdr = addr_detect_enable & events.addrDetect & ~startup;
  wire srcWk  = wakeDone & wakePend & receive_irq_enable;
  wire anyReq = srcTxE | srcTxI | srcRx | srcOvr | srcAdr | srcWk;
  wire gated = anyReq & sie;
  wire next_vector = gated & gie & ~stackFull & ~clockStopped;

  wire [7:0] statusIn = {3'h0, startup, txIdleLvl, txEmptyLvl, overrunFlag, rxAvail};
  wire [1:0] sysStat  = {startup, wakePend};

  uirq_avalon u_regs (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .ctrlOne     (ctrlOne),
    .ctrlTwo     (ctrlTwo),
    .sysCtl      (sysCtl),
    .statusIn    (statusIn),
    .sysStat     (sysStat),
    .statusRead  (statusRead)
  );

  uirq_wake #(
    .STARTUP_CYC (STARTUP_CYC)
  ) u_wake (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .armed    (armedAtEntry),
    .lowPower (lowPower),
    .rxPin    (rxPin),
    .wakeReq  (wakeReq),
    .startup  (startup),
    .wakeDone (wakeDone)
  );

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lowPowerLast <= 1'b0;
      armedAtEntry <= 1'b0;
      wakePend     <= 1'b0;
      wakeOut      <= 1'b0;
      serialRun    <= 1'b0;
      rxGate       <= 1'b0;
    end
    else
    begin
      lowPowerLast <= lowPower;
      if (lowPower & ~lowPowerLast)
        armedAtEntry <= armNow;
      else if (~lowPower)
        armedAtEntry <= 1'b0;
      if (wakeReq)
        wakePend <= gie & sie;
      else if (wakeDone)
        wakePend <= 1'b0;
      wakeOut <= wakeReq;
      serialRun <= uEn & ~clockStopped;
      rxGate    <= uEn & receiver_enable & ~clockStopped & ~startup;
    end
  end

  // overrun flag cleared only by status access then buffer read; rxAvail follows rxBufEmpty inverted
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxAvail     <= 1'b0;
      overrunFlag <= 1'b0;
      statusSeen  <= 1'b0;
    end
    else
    begin
      rxAvail <= ~rxBufEmpty;
      if (statusRead)
        statusSeen <= 1'b1;
      else if (rxBufRead)
        statusSeen <= 1'b0;
      // Set wins over a clear in the same cycle
      if (events.overrun)
        overrunFlag <= 1'b1;
      else if (statusSeen & rxBufRead)
        overrunFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      anyReqLast  <= 1'b0;
      irq_n       <= 1'b1;
    end
    else
    begin
      anyReqLast  <= next_vector;
      irq_n       <= ~(next_vector & ~anyReqLast);
    end
  end

  // registers hold across low power
  // Only armedAtEntry and lowPowerLast above are loaded or cleared by lowPower, so register contents survive idle and sleep
endmodule

//--- uirq_checker.sv
// Concurrent checks on the ports of the interrupt and wake top
`timescale 1ns/100ps
module uirq_checker
  import uirq_pkg::*;
#(
  parameter int STARTUP_CYC = UIRQ_STARTUP_CYC
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Core state
  input wire logic stackFull,
  input wire logic clockStopped,
  // Outputs
  input wire logic irq_n,
  input wire logic wakeOut,
  input wire logic serialRun,
  input wire logic rxGate
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_irq_one_cycle: assert property (!irq_n |=> irq_n)
    else $error("irq low longer than one cycle");
  chk_irq_stack_free: assert property (!irq_n |-> !$past(stackFull))
    else $error("irq while stack full");
  chk_freeze_on_stop: assert property (clockStopped |=> !serialRun)
    else $error("serial core runs with clock stopped");
  chk_wake_one_pulse: assert property (wakeOut |=> !wakeOut)
    else $error("wake pulse too long");
  chk_rx_ignored: assert property (wakeOut |=> !rxGate [*4])
    else $error("receiver open during start-up");
  chk_wake_irq_held: assert property (wakeOut |=> irq_n [*6])
    else $error("irq before start-up elapsed");
  chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without request");
  cover property (!irq_n);
  cover property (wakeOut);
  cover property (clockStopped && !serialRun);
endmodule

bind uirq_top uirq_checker #(.STARTUP_CYC(STARTUP_CYC)) u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .read(read), .write(write), .waitrequest(waitrequest),
  .stackFull(stackFull), .clockStopped(clockStopped), .irq_n(irq_n), .wakeOut(wakeOut),
  .serialRun(serialRun), .rxGate(rxGate));

//--- uirq_partner.sv
// Serial core and remote transmitter model: event strobes, words and rx line
`timescale 1ns/100ps
module uirq_partner
  import uirq_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Core side
  output uirq_evt_t  events,
  output uirq_word_t rxWord,
  output logic       rxPin
);
  int lowCnt;
  initial
  begin
    events = '0;
    rxWord = 9'h155;
    rxPin = 1'b1;
    lowCnt = 0;
  end
  // word valid only with its load strobe
  task automatic send(input uirq_evt_t e, input uirq_word_t w);
    @(posedge clk_sys);
    events <= e;
    rxWord <= w;
    @(posedge clk_sys);
    events <= '0;
    rxWord <= ~w;
  endtask
  // falling edge as a start bit
  task automatic fall();
    @(posedge clk_sys);
    rxPin <= 1'b0;
  endtask
  // Line returns to idle high after a short low, like a start bit
  always @(posedge clk_sys)
    if (rxPin === 1'b0)
    begin
      lowCnt <= (lowCnt == 3) ? 0 : lowCnt + 1;
      if (lowCnt == 3)
        rxPin <= 1'b1;
    end
endmodule

//--- uirq_tb_top.sv
// Self-checking bench for the interrupt, address detect and wake top
`timescale 1ns/100ps
module uirq_tb_top
  import uirq_pkg::*;
;
  logic clk_sys, reset_n, read, write, waitrequest, irq_n, wakeOut, serialRun, rxGate;
  logic rxBufEmpty, rxBufRead, txEmptyLvl, txIdleLvl, clockStopped, lowPower, stackFull;
  logic rxPin;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  uirq_evt_t events;
  uirq_word_t rxWord;
  int err_total, checked, n;
  logic [7:0] en [5] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h10};
  logic [8:0] ad [5] = '{9'h000, 9'h000, 9'h080, 9'h100, 9'h080};
  logic [1:0] am [5] = '{2'b00, 2'b10, 2'b10, 2'b11, 2'b11};
  logic [31:0] ax [5] = '{32'h1, 32'h0, 32'h1, 32'h1, 32'h0};
  uirq_top #(.STARTUP_CYC(8)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .events(events), .rxWord(rxWord), .rxBufEmpty(rxBufEmpty),
    .rxBufRead(rxBufRead), .txEmptyLvl(txEmptyLvl), .txIdleLvl(txIdleLvl),
    .clockStopped(clockStopped), .lowPower(lowPower), .stackFull(stackFull), .rxPin(rxPin),
    .irq_n(irq_n), .wakeOut(wakeOut), .serialRun(serialRun), .rxGate(rxGate));
  uirq_partner P (.clk_sys(clk_sys), .events(events), .rxWord(rxWord), .rxPin(rxPin));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, d};
    do @(posedge clk_sys); while (waitrequest !== 1'b0 && ++k < 100);
    if (k >= 100)
    begin
      err_total++;
      $display("unexpected at %0t: bus answer never came", $time);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    cmp(q, {24'h0, exp});
  endtask
  // Counts irq (w=0) or wake (w=1) pulses over c cycles
  task automatic cnt(input int c, input bit w, input logic [31:0] exp);
    n = 0;
    repeat (c)
    begin
      @(posedge clk_sys);
      if ((w ? wakeOut : !irq_n) === 1'b1) n++;
    end
    cmp(32'(n), exp);
  endtask
  task automatic ev(input uirq_evt_t e, input uirq_word_t w, input logic [31:0] exp);
    P.send(e, w);
    cnt(6, 1'b0, exp);
  endtask
  task automatic wake(input logic [7:0] c2, input logic [7:0] sc,
                      input logic [31:0] w, input logic [31:0] i);
    bus(1'b1, 4'hC, sc);
    bus(1'b1, 4'h8, c2);
    @(posedge clk_sys) lowPower <= 1'b1;
    P.fall();
    cnt(6, 1'b1, w);
    cmp(32'(rxGate), 32'h0);
    lowPower <= 1'b0;
    cnt(20, 1'b0, i);
    cmp(32'(rxGate), 32'(c2[UIRQ_C2_RECEIVER_ENABLE]));
    rd(4'h8, c2);
  endtask
  initial
  begin
    {err_total, checked} = '0;
    {read, write, clockStopped, lowPower, stackFull, rxBufRead, txEmptyLvl, txIdleLvl} = '0;
    {rxBufEmpty, address, writedata} = {1'b1, 36'h0};
    reset_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (en[i]) rd(4'(4 * i), 8'h00);
    bus(1'b1, 4'h0, 8'hFF);
    rd(4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h01);
    bus(1'b1, 4'hC, 8'h03);
    foreach (en[i])
    begin
      bus(1'b1, 4'h8, en[i]);
      ev(5'h10 >> i, 9'h000, 32'h1);
      bus(1'b1, 4'h8, ~en[i] & 8'h37);
      ev(5'h10 >> i, 9'h000, 32'h0);
    end
    bus(1'b1, 4'h8, 8'h10);
    ev(5'h01, 9'h000, 32'h1);
    // Overrun was set above; buffer now holds data
    @(posedge clk_sys) rxBufEmpty <= 1'b0;
    rd(4'h0, 8'h03);
    @(posedge clk_sys) rxBufRead <= 1'b1;
    @(posedge clk_sys) rxBufRead <= 1'b0;
    rd(4'h0, 8'h01);
    rxBufEmpty <= 1'b1;
    // Parity kept off whenever address detect is on
    foreach (am[i])
    begin
      bus(1'b1, 4'h4, {6'h0, am[i][0], 1'b1});
      bus(1'b1, 4'h8, {3'h0, am[i][1], 4'h4});
      ev(5'h04, ad[i], ax[i]);
    end
    bus(1'b1, 4'h8, 8'h04);
    ev(5'h04, 9'h180, 32'h1);
    bus(1'b1, 4'h8, 8'h01);
    @(posedge clk_sys) stackFull <= 1'b1;
    ev(5'h10, 9'h000, 32'h0);
    stackFull <= 1'b0;
    bus(1'b1, 4'hC, 8'h01);
    ev(5'h10, 9'h000, 32'h0);
    bus(1'b1, 4'hC, 8'h02);
    ev(5'h10, 9'h000, 32'h0);
    @(posedge clk_sys) clockStopped <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp(32'(serialRun), 32'h0);
    clockStopped <= 1'b0;
    repeat (3) @(posedge clk_sys);
    cmp(32'(serialRun), 32'h1);
    // Software lets transfers finish before low power
    wake(8'h2C, 8'h03, 32'h1, 32'h1);
    wake(8'h0C, 8'h03, 32'h0, 32'h0);
    wake(8'h2C, 8'h02, 32'h1, 32'h0);
    test_done();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    $display("unexpected at %0t: run limit reached", $time);
    test_done();
  end
endmodule
